// ---- core/wdts_pkg.sv ----
// Package for the watchdog and Sleep block: register map, fields, reset values, timing.
// Assumes a 200 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package wdts_pkg;

    // Register word indices; 0x81 is not a multiple of four, so these are not byte offsets
    localparam logic [7:0]  CTRL_IDX      = 8'h18;
    localparam logic [7:0]  OPTION_IDX    = 8'h81;
    localparam logic [7:0]  SYS_IDX       = 8'h20;
    localparam logic [7:0]  STATUS_IDX    = 8'h21;
    localparam logic [11:0] CTRL_ADDR     = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] OPTION_ADDR   = {2'h0, OPTION_IDX, 2'h0};
    localparam logic [11:0] SYS_ADDR      = {2'h0, SYS_IDX, 2'h0};
    localparam logic [11:0] STATUS_ADDR   = {2'h0, STATUS_IDX, 2'h0};

    // Reset values
    localparam logic [7:0]  CTRL_RST      = 8'h08;
    localparam logic [7:0]  OPTION_RST    = 8'hFF;

    // Field positions
    localparam int          SWEN_BIT      = 0;
    localparam int          PER_LSB       = 1;
    localparam int          PER_MSB       = 4;
    localparam int          PSA_BIT       = 3;
    localparam int          PS_LSB        = 0;
    localparam int          PS_MSB        = 2;
    localparam logic [3:0]  PER_MAX_CODE  = 4'hB;
    localparam int          PRE_MIN_LOG2  = 5;

    // System command bits (write-one pulses)
    localparam int          CMD_CLR_BIT   = 0;
    localparam int          CMD_SLEEP_BIT = 1;
    localparam int          CMD_WAKE_BIT  = 2;
    localparam int          CMD_OSCF_BIT  = 3;

    // Low-frequency oscillator rate and system clock
    localparam int          LFOSC_HZ      = 31000;
    localparam int          SYS_HZ        = 200000000;
    localparam int          LF_DIV        = SYS_HZ / LFOSC_HZ;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        WD_AWAKE,
        WD_ASLEEP,
        WD_OST_HOLD
    } wdts_mode_t;

    // Status flags grouped for transport
    typedef struct packed {
        logic power_down_flag;
        logic watchdog_expired_flag;
        logic lf_osc_stable;
    } wdts_flags_t;

endpackage : wdts_pkg

// ---- core/wdts_prescale.sv ----
// Dedicated watchdog prescaler, separate from the timer-zero scaler.
// Assumes tick_en pulses once per low-frequency oscillator period.
`timescale 1ns/1ps
module wdts_prescale #(
    parameter int WIDTH = 16
) (
    input  wire logic       clk,       // System clock
    input  wire logic       rst_n,     // Asynchronous reset, active low
    input  wire logic       clr,       // Synchronous clear
    input  wire logic       tick_en,   // Oscillator tick
    input  wire logic [3:0] log2_sel,  // Ratio select, 0 selects 1:32
    output logic            out_pulse  // One pulse per selected ratio
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] mask;

    // Mask of the low bits that must all be one at terminal count
    always_comb begin
        mask = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (i < int'(log2_sel) + wdts_pkg::PRE_MIN_LOG2) begin
                mask[i] = 1'b1;
            end
        end
    end

    // Free running counter, cleared on request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (tick_en) begin
            cnt_q <= ((cnt_q & mask) == mask) ? '0 : cnt_q + 1'b1;
        end
    end

    // Terminal count only; clr does not enter it, so a clear fed by it cannot loop back
    assign out_pulse = tick_en && ((cnt_q & mask) == mask);
endmodule : wdts_prescale

// ---- core/wdts_top.sv ----
// Watchdog timer with Sleep entry, reached over AXI4-Lite.
// Assumes pins and strobes from the core arrive synchronous to SYS_CLK except WDT_FUSE_EN_I.
//
// Overview of operation
// - Time base is a tick derived at the 31 kHz low-frequency rate.
// - Watchdog use of the oscillator never sets the oscillator stable flag.
// - Every reset loads control with period code 1:512 and enable cleared.
// - Ripple counter held in reset while start-up timer counts; then resumes.
// - Dedicated 16-bit prescaler divides by 32 up to 65536.
// - Watchdog prescaler is separate from the timer-zero prescaler.
// - Fuse enable set runs watchdog always; software enable ignored.
// - Fuse clear lets software enable bit turn watchdog on and off.
// - Counter cleared when disabled, on clear instruction, or oscillator failure.
// - Leaving Sleep with crystal clock keeps watchdog cleared until start-up ends.
// - Period field bits 4..1 double from 1:32 to 1:65536; 12..15 reserved.
// - Control bits 7..5 read zero.
// - Sleep command enters power-down mode.
// - Entering Sleep clears the watchdog counter, which keeps counting.
// - Entering Sleep clears power-down flag and sets expired flag.
// - In Sleep oscillator driver is off and pins hold their drive.
// - Watchdog reset is internal only, never drives the external reset pin.
// - Every wake from Sleep clears the watchdog.
// - Time-out in Sleep wakes device and clears the expired flag.
// - Time-out when awake requests a non-power-up device reset.
`timescale 1ns/1ps
module wdts_top #(
    parameter int PRE_WIDTH  = 16,
    parameter int LF_DIVIDE  = wdts_pkg::LF_DIV,
    parameter int PINS       = 12
) (
    input  wire logic            SYS_CLK,         // 200 MHz clock
    input  wire logic            RST_N,           // Asynchronous reset, active low
    input  wire logic            WDT_FUSE_EN_I,   // Configuration watchdog enable pin
    input  wire logic            XTAL_MODE_I,     // System clock is crystal type
    input  wire logic            OST_BUSY_I,      // Start-up timer counting, same clock
    input  wire logic [PINS-1:0] PIN_OUT_I,       // Pin drive from ports
    input  wire logic [PINS-1:0] PIN_OE_I,        // Pin enable from ports
    input  wire logic [11:0]     S_AXI_AWADDR,    // Write address
    input  wire logic            S_AXI_AWVALID,   // Write address valid
    output logic                 S_AXI_AWREADY,   // Write address ready
    input  wire logic [31:0]     S_AXI_WDATA,     // Write data
    input  wire logic [3:0]      S_AXI_WSTRB,     // Write strobes
    input  wire logic            S_AXI_WVALID,    // Write data valid
    output logic                 S_AXI_WREADY,    // Write data ready
    output logic [1:0]           S_AXI_BRESP,     // Write response
    output logic                 S_AXI_BVALID,    // Write response valid
    input  wire logic            S_AXI_BREADY,    // Write response ready
    input  wire logic [11:0]     S_AXI_ARADDR,    // Read address
    input  wire logic            S_AXI_ARVALID,   // Read address valid
    output logic                 S_AXI_ARREADY,   // Read address ready
    output logic [31:0]          S_AXI_RDATA,     // Read data
    output logic [1:0]           S_AXI_RRESP,     // Read response
    output logic                 S_AXI_RVALID,    // Read valid
    input  wire logic            S_AXI_RREADY,    // Read ready
    output logic                 WDT_RESET_O,     // Internal reset request pulse
    output logic                 WAKE_O,          // Wake-up pulse
    output logic                 SLEEP_O,         // Device in power-down
    output logic                 OSC_DRV_EN_O,    // Main oscillator driver on
    output logic                 EXT_RST_PIN_OE_O,// External reset pin drive enable
    output logic [PINS-1:0]      PIN_OUT_O,       // Pin drive
    output logic [PINS-1:0]      PIN_OE_O         // Pin enable
);
    logic [7:0]           ctrl_q;
    logic [7:0]           option_q;
    wdts_pkg::wdts_flags_t flags_q;
    wdts_pkg::wdts_mode_t mode_q;
    logic [PINS-1:0]      pin_out_q;
    logic [PINS-1:0]      pin_oe_q;
    logic                 fuse_s1_q;
    logic                 fuse_q;
    logic [15:0]          lf_cnt_q;
    logic                 lf_tick;
    logic [7:0]           post_q;
    logic [7:0]           ripple_q;
    logic                 pre_pulse;
    logic                 wdt_on;
    logic                 wdt_clr;
    logic                 timeout;
    logic                 aw_q;
    logic                 w_q;
    logic [11:0]          awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 do_write;
    logic                 cmd_clr;
    logic                 cmd_sleep;
    logic                 cmd_wake;
    logic                 cmd_oscf;
    logic                 enter_sleep;
    logic                 wake;
    logic                 ost_hold;

    // Fuse pin synchroniser
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fuse_s1_q <= 1'b0;
            fuse_q    <= 1'b0;
        end else begin
            fuse_s1_q <= WDT_FUSE_EN_I;
            fuse_q    <= fuse_s1_q;
        end
    end

    // Low-frequency tick divider
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lf_cnt_q <= '0;
        end else if (lf_cnt_q == 16'(LF_DIVIDE - 1)) begin
            lf_cnt_q <= '0;
        end else begin
            lf_cnt_q <= lf_cnt_q + 16'h0001;
        end
    end
    assign lf_tick = (lf_cnt_q == 16'(LF_DIVIDE - 1));

    // Enable and clear conditions
    assign wdt_on      = fuse_q | ctrl_q[wdts_pkg::SWEN_BIT];
    assign ost_hold    = OST_BUSY_I | (mode_q == wdts_pkg::WD_OST_HOLD);
    assign enter_sleep = cmd_sleep && (mode_q == wdts_pkg::WD_AWAKE);
    assign wdt_clr     = !wdt_on || cmd_clr || cmd_oscf || ost_hold
                         || enter_sleep || wake;

    // Dedicated prescaler with ratio 1:32 to 1:65536
    wdts_prescale #(
        .WIDTH    (PRE_WIDTH)
    ) u_pre (
        .clk      (SYS_CLK),
        .rst_n    (RST_N),
        .clr      (wdt_clr),
        .tick_en  (lf_tick),
        .log2_sel (ctrl_q[wdts_pkg::PER_MSB:wdts_pkg::PER_LSB]),
        .out_pulse(pre_pulse)
    );

    // Shared postscaler when assigned to the watchdog
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            post_q <= '0;
        end else if (wdt_clr) begin
            post_q <= '0;
        end else if (pre_pulse) begin
            post_q <= post_q + 8'h01;
        end
    end

    // Ripple counter stage selected by postscaler
    always_comb begin
        ripple_q = 8'h00;
        ripple_q[option_q[wdts_pkg::PS_MSB:wdts_pkg::PS_LSB]] = 1'b1;
        if (!option_q[wdts_pkg::PSA_BIT]) begin
            timeout = pre_pulse;
        end else begin
            timeout = pre_pulse && ((post_q & (ripple_q - 8'h01)) == (ripple_q - 8'h01));
        end
    end

    // Sleep and start-up sequencing
    assign wake = (mode_q == wdts_pkg::WD_ASLEEP) && (cmd_wake || timeout);
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q <= wdts_pkg::WD_AWAKE;
        end else begin
            case (mode_q)
                wdts_pkg::WD_AWAKE: begin
                    if (enter_sleep) begin
                        mode_q <= wdts_pkg::WD_ASLEEP;
                    end
                end
                wdts_pkg::WD_ASLEEP: begin
                    if (wake) begin
                        mode_q <= XTAL_MODE_I ? wdts_pkg::WD_OST_HOLD
                                              : wdts_pkg::WD_AWAKE;
                    end
                end
                default: begin
                    if (!OST_BUSY_I) begin
                        mode_q <= wdts_pkg::WD_AWAKE;
                    end
                end
            endcase
        end
    end

    // Status flags; stable flag never driven by watchdog
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_q <= '{power_down_flag: 1'b1, watchdog_expired_flag: 1'b1,
                         lf_osc_stable: 1'b0};
        end else if (enter_sleep) begin
            flags_q.power_down_flag       <= 1'b0;
            flags_q.watchdog_expired_flag <= 1'b1;
        end else if (timeout && wdt_on && (!wdt_clr || wake)) begin
            flags_q.watchdog_expired_flag <= 1'b0;
        end
    end

    // Time-out pulses: wake when asleep, reset when awake
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            WDT_RESET_O <= 1'b0;
            WAKE_O      <= 1'b0;
        end else begin
            WDT_RESET_O <= timeout && !wdt_clr && (mode_q == wdts_pkg::WD_AWAKE);
            WAKE_O      <= wake;
        end
    end
    assign EXT_RST_PIN_OE_O = 1'b0;

    // Pin hold and oscillator driver
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
        end else if (mode_q != wdts_pkg::WD_ASLEEP && !enter_sleep) begin
            pin_out_q <= PIN_OUT_I;
            pin_oe_q  <= PIN_OE_I;
        end
    end
    assign PIN_OUT_O    = pin_out_q;
    assign PIN_OE_O     = pin_oe_q;
    assign SLEEP_O      = (mode_q == wdts_pkg::WD_ASLEEP);
    assign OSC_DRV_EN_O = (mode_q != wdts_pkg::WD_ASLEEP);

    // AXI write channel capture
    assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_q && !S_AXI_BVALID;
    assign do_write      = aw_q && w_q;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_q     <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_q <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_q     <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_q <= 1'b0;
            end
        end
    end

    // Command pulses from the system register
    assign cmd_clr   = do_write && awaddr_q == wdts_pkg::SYS_ADDR && wstrb_q[0]
                       && wdata_q[wdts_pkg::CMD_CLR_BIT];
    assign cmd_sleep = do_write && awaddr_q == wdts_pkg::SYS_ADDR && wstrb_q[0]
                       && wdata_q[wdts_pkg::CMD_SLEEP_BIT];
    assign cmd_wake  = do_write && awaddr_q == wdts_pkg::SYS_ADDR && wstrb_q[0]
                       && wdata_q[wdts_pkg::CMD_WAKE_BIT];
    assign cmd_oscf  = do_write && awaddr_q == wdts_pkg::SYS_ADDR && wstrb_q[0]
                       && wdata_q[wdts_pkg::CMD_OSCF_BIT];

    // Register writes and write response
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q       <= wdts_pkg::CTRL_RST;
            option_q     <= wdts_pkg::OPTION_RST;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= wdts_pkg::RESP_OKAY;
        end else begin
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wdts_pkg::RESP_OKAY;
                if (awaddr_q == wdts_pkg::CTRL_ADDR) begin
                    if (wstrb_q[0] && wdata_q[4:1] <= wdts_pkg::PER_MAX_CODE) begin
                        ctrl_q <= {3'h0, wdata_q[4:0]};
                    end
                end else if (awaddr_q == wdts_pkg::OPTION_ADDR) begin
                    if (wstrb_q[0]) begin
                        option_q <= wdata_q[7:0];
                    end
                end else if (awaddr_q != wdts_pkg::SYS_ADDR) begin
                    S_AXI_BRESP <= wdts_pkg::RESP_SLVERR;
                end
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Read channel
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= '0;
            S_AXI_RRESP  <= wdts_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= wdts_pkg::RESP_OKAY;
            if (S_AXI_ARADDR == wdts_pkg::CTRL_ADDR) begin
                S_AXI_RDATA <= {24'h0, 3'h0, ctrl_q[4:0]};
            end else if (S_AXI_ARADDR == wdts_pkg::OPTION_ADDR) begin
                S_AXI_RDATA <= {24'h0, option_q};
            end else if (S_AXI_ARADDR == wdts_pkg::SYS_ADDR) begin
                S_AXI_RDATA <= '0;
            end else if (S_AXI_ARADDR == wdts_pkg::STATUS_ADDR) begin
                S_AXI_RDATA <= {27'h0, fuse_q, mode_q == wdts_pkg::WD_ASLEEP,
                                flags_q};
            end else begin
                S_AXI_RDATA <= '0;
                S_AXI_RRESP <= wdts_pkg::RESP_SLVERR;
            end
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
endmodule : wdts_top

// ---- sim/wdts_checker.sv ----
// Checker for wdts_top: bus answers, Sleep outputs, pin hold and reset pin.
// Assumes it is bound to wdts_top and sees only its ports.
`timescale 1ns/1ps
module wdts_checker #(
    parameter int PINS = 12
) (
    input wire logic            SYS_CLK,          // Clock
    input wire logic            RST_N,            // Reset, active low
    input wire logic            S_AXI_AWVALID,    // Write address valid
    input wire logic            S_AXI_AWREADY,    // Write address ready
    input wire logic            S_AXI_WVALID,     // Write data valid
    input wire logic            S_AXI_WREADY,     // Write data ready
    input wire logic [1:0]      S_AXI_BRESP,      // Write response
    input wire logic            S_AXI_BVALID,     // Write response valid
    input wire logic            S_AXI_BREADY,     // Write response ready
    input wire logic [11:0]     S_AXI_ARADDR,     // Read address
    input wire logic            S_AXI_ARVALID,    // Read address valid
    input wire logic            S_AXI_ARREADY,    // Read address ready
    input wire logic [31:0]     S_AXI_RDATA,      // Read data
    input wire logic            S_AXI_RVALID,     // Read valid
    input wire logic            S_AXI_RREADY,     // Read ready
    input wire logic            WDT_RESET_O,      // Reset request
    input wire logic            WAKE_O,           // Wake pulse
    input wire logic            SLEEP_O,          // Asleep
    input wire logic            OSC_DRV_EN_O,     // Oscillator driver on
    input wire logic            EXT_RST_PIN_OE_O, // Reset pin drive
    input wire logic [PINS-1:0] PIN_OUT_I,        // Pin drive in
    input wire logic [PINS-1:0] PIN_OUT_O         // Pin drive out
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic [11:0] ar_q;

    // Last read address taken
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) ar_q <= 12'h000;
        else if (S_AXI_ARVALID && S_AXI_ARREADY) ar_q <= S_AXI_ARADDR;
    end

    property p_ext_pin; EXT_RST_PIN_OE_O == 1'b0; endproperty
    a_ext_pin: assert property (p_ext_pin) else $error("reset pin driven");
    property p_osc_off; SLEEP_O |-> !OSC_DRV_EN_O; endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator on in sleep");
    property p_pin_hold; SLEEP_O && $past(SLEEP_O) |-> $stable(PIN_OUT_O); endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pins moved in sleep");
    property p_pin_copy;
        !SLEEP_O && !$past(SLEEP_O) && $past(RST_N) |-> PIN_OUT_O == $past(PIN_OUT_I);
    endproperty
    a_pin_copy: assert property (p_pin_copy) else $error("pins not passed");
    property p_rst_pulse; WDT_RESET_O |=> !WDT_RESET_O; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
    property p_no_rst_asleep; SLEEP_O |-> !WDT_RESET_O; endproperty
    a_no_rst_asleep: assert property (p_no_rst_asleep) else $error("reset in sleep");
    property p_wake_pulse; WAKE_O |=> !WAKE_O; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
    property p_b_answer;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("no write answer");
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_r_answer: assert property (p_r_answer) else $error("no read answer");
    property p_ctrl_top; S_AXI_RVALID && ar_q == wdts_pkg::CTRL_ADDR |-> S_AXI_RDATA[31:5] == 27'h0;
    endproperty
    a_ctrl_top: assert property (p_ctrl_top) else $error("control upper bits set");
    c_sleep: cover property ($rose(SLEEP_O));
    c_wake: cover property (WAKE_O);
    c_reset: cover property (WDT_RESET_O);
endmodule : wdts_checker

// ---- sim/wdts_top_test.sv ----
// Bench for wdts_top: registers, time-outs, fuse, start-up hold and Sleep.
// Assumes a tick every 4 clocks; a monitor compares bus answers with queued notes.
`timescale 1ns/1ps
module wdts_top_test;
    localparam int LF = 4;
    localparam int T0 = 32 * LF; // Time-out at period code 0
    localparam logic [1:0]  OK = wdts_pkg::RESP_OKAY;
    localparam logic [11:0] CT = wdts_pkg::CTRL_ADDR;
    localparam logic [11:0] OP = wdts_pkg::OPTION_ADDR;
    localparam logic [11:0] SY = wdts_pkg::SYS_ADDR;
    localparam logic [11:0] ST = wdts_pkg::STATUS_ADDR;
    logic        clk, rst_n, fuse, xtal, osc_startup_timer;
    logic [11:0] pin_out, pin_oe, awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, wdt_rst, wake, sleep, osc_en;
    logic [1:0]  exp_b[$];
    logic [33:0] exp_r[$];
    logic [7:0]  cur;
    int          fail_count, checks_done;

    wdts_top #(.LF_DIVIDE(LF)) uut (
        .SYS_CLK(clk), .RST_N(rst_n), .WDT_FUSE_EN_I(fuse), .XTAL_MODE_I(xtal),
        .OST_BUSY_I(osc_startup_timer), .PIN_OUT_I(pin_out), .PIN_OE_I(pin_oe),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .WDT_RESET_O(wdt_rst),
        .WAKE_O(wake), .SLEEP_O(sleep), .OSC_DRV_EN_O(osc_en),
        .EXT_RST_PIN_OE_O(), .PIN_OUT_O(), .PIN_OE_O()
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // Register write; the answer is noted for the monitor
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        bit aw_ok = 1'b0, w_ok = 1'b0;
        exp_b.push_back(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= ($urandom() << 8) | {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awready && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
    endtask : wr

    // Register read; the expected word is noted for the monitor
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        exp_r.push_back({OK, 24'h0, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask : rd

    // Cycles until a wake or reset pulse must land near t
    task automatic expect_event(input bit want_wake, input int t);
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(want_wake ? wake : wdt_rst) && n < t + 50);
        check({33'h0, (n >= t - 8 && n <= t + 8)}, 34'h1);
    endtask : expect_event

    // Restart the counter with code 0 and the software enable set
    task automatic restart();
        wr(CT, 8'h00, OK);
        wr(CT, 8'h01, OK);
    endtask : restart

    // Monitor of bus answers
    always @(posedge clk) begin
        if (rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
        if (bvalid && bready) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h3743));
        {rst_n, fuse, xtal, osc_startup_timer, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        pin_out = 12'h000;
        pin_oe = 12'h000;
        fail_count = 0;
        checks_done = 0;
        cur = 8'h08;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(CT, 8'h08);
        rd(OP, 8'hFF);
        rd(ST, 8'h06);
        wr(12'h010, 8'h00, wdts_pkg::RESP_SLVERR);
        $display("Test reset values done");
        for (int c = 0; c < 16; c++) begin
            wr(CT, {3'h7, c[3:0], 1'b0}, OK);
            if (c <= 11) cur = {3'h0, c[3:0], 1'b0};
            rd(CT, cur);
        end
        $display("Test period codes done");
        wr(OP, 8'h00, OK);
        restart();
        expect_event(1'b0, T0);
        rd(ST, 8'h04);
        wr(CT, 8'h00, OK);
        wr(CT, 8'h03, OK);
        expect_event(1'b0, 2 * T0);
        for (int b = 0; b < 2; b++) begin
            restart();
            repeat (T0 / 2) @(posedge clk);
            wr(SY, b ? 8'h08 : 8'h01, OK);
            expect_event(1'b0, T0);
        end
        for (int p = 0; p < 3; p++) begin
            wr(OP, {5'h01, p[2:0]}, OK);
            restart();
            expect_event(1'b0, T0 << p);
        end
        wr(OP, 8'h00, OK);
        $display("Test time-outs done");
        wr(CT, 8'h00, OK);
        fuse <= 1'b1;
        expect_event(1'b0, T0);
        rd(ST, 8'h14);
        fuse <= 1'b0;
        osc_startup_timer <= 1'b1;
        restart();
        fork
            begin
                repeat (400) @(posedge clk);
                osc_startup_timer <= 1'b0;
            end
        join_none
        expect_event(1'b0, 400 + T0);
        $display("Test fuse and start-up hold done");
        restart();
        pin_out <= 12'($urandom());
        pin_oe <= 12'($urandom());
        wr(SY, 8'h02, OK);
        check({32'h0, sleep, osc_en}, 34'h2);
        pin_out <= ~pin_out;
        expect_event(1'b1, T0);
        rd(ST, 8'h00);
        expect_event(1'b0, T0);
        restart();
        wr(SY, 8'h02, OK);
        rd(ST, 8'h0A);
        repeat (T0 / 2) @(posedge clk);
        wr(SY, 8'h04, OK);
        expect_event(1'b0, T0);
        $display("Test sleep done");
        xtal <= 1'b1;
        restart();
        wr(SY, 8'h02, OK);
        osc_startup_timer <= 1'b1;
        wr(SY, 8'h04, OK);
        fork
            begin
                repeat (300) @(posedge clk);
                osc_startup_timer <= 1'b0;
            end
        join_none
        expect_event(1'b0, 300 + T0);
        $display("Test crystal wake done");
        tally_and_finish();
    end
endmodule : wdts_top_test

bind wdts_top wdts_checker #(.PINS(PINS)) chk (.*);
